//--- logic/fep_pcs.sv
// Coding path of one fast ethernet port: transmit encoder and receive decoder
`timescale 1ns/1ps
// Functional notes
// - Invalid code-group during valid data raises error
// - Transmit key seed comes from PHY address
// - Groups serialised into one NRZI bit stream
// - Three-level output steps on one, holds zero
// - Recovered levels turned back into NRZI bits
// - Six-bit line samples passed on each cycle
// - Timing unit picks the sampling clock phase
// - Descrambler key learnt from idle, then locked
// - No idle within window: abort, resynchronise
// - Group boundary fixed by idle followed by J
// - Valid groups decoded to receive nibbles
// - Start delimiter gives two preamble nibbles, valid
// - Receive valid rises on start delimiter
// - End pair or two idles drop valid, carrier
// - Unexpected group in frame raises error
// - Bad start delimiter: error, 1110, valid low
// - Whole path runs on the one line clock
// - Frame start sends J then K
// - Frame end sends T then R
// - Idle groups sent between frames
module fep_pcs
  import fep_pkg::*;
#(
  parameter int PHASES = 4,
  parameter int IDLE_CYC = fep_pkg::IDLE_WIN_CYC
) (
  input wire logic i_clk,  // single coding clock
  input wire logic i_rst,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  input wire logic [3:0] i_tx_d,
  output logic o_tx_nrzi,
  output logic [1:0] o_tx_mlt3,
  input wire logic [5:0] i_adc_sample,
  output logic [5:0] o_dsp_sample,
  input wire logic [2*PHASES-1:0] i_rx_levels,
  input wire logic [$clog2(PHASES)-1:0] i_phase_sel,
  output logic o_rx_strobe,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic o_crs,
  output logic [3:0] o_rx_d,
  output logic o_rx_locked
);
  import fep_pkg::*;

  // ---------------- Transmit ----------------
  logic [TXW_W-1:0] fifo_data;   // Oldest queued word
  logic fifo_valid;              // Queue holds a word
  logic fifo_pop;                // Encoder takes the word
  fep_tx_state_e tx_state;       // Framing state
  fep_tx_state_e next_tx_state;
  logic [4:0] tx_sr;             // Group being sent, top bit first
  logic [4:0] next_tx_sr;
  logic [2:0] tx_cnt;            // Bit position in the group
  logic [2:0] next_tx_cnt;
  logic [KEY_W-1:0] tx_key;      // Scrambler key register
  logic [KEY_W-1:0] next_tx_key;
  logic tx_seeded;               // Seed loaded after reset
  logic [1:0] mlt_idx;           // Position in the 0,+,0,- cycle
  logic [1:0] next_mlt_idx;
  logic next_nrzi;
  logic [1:0] next_mlt3;
  logic tx_load;                 // Fresh group enters this cycle
  logic scr_bit;                 // Scrambled code bit on the line
  logic [4:0] tx_code;           // Group chosen at load

  // Nibbles from the MAC wait here; a stalled encoder pushes back on the MAC
  fep_fifo #(.W(TXW_W), .D(TX_FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .i_data({i_tx_en, i_tx_er, i_tx_d}),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );

  // Framing, serialiser, scrambler, NRZI and three-level encoder
  always_comb begin
    tx_load = (tx_cnt == 3'd4);
    fifo_pop = 1'b0;
    tx_code = CG_IDLE;
    next_tx_state = tx_state;
    if (tx_load) begin
      unique case (tx_state)
        TX_IDLE: begin
          if (fifo_valid && fifo_data[TXW_EN]) begin
            tx_code = CG_J;
            fifo_pop = 1'b1;
            next_tx_state = TX_K;
          end else begin
            tx_code = CG_IDLE;
            fifo_pop = fifo_valid;
          end
        end
        TX_K: begin
          tx_code = CG_K;
          fifo_pop = fifo_valid && fifo_data[TXW_EN];
          next_tx_state = TX_DATA;
        end
        TX_DATA: begin
          if (fifo_valid && fifo_data[TXW_EN]) begin
            tx_code = fifo_data[TXW_ER] ? CG_H : fep_enc(fifo_data[3:0]);
            fifo_pop = 1'b1;
          end else begin
            // Enable fell or the MAC ran dry: close the frame
            tx_code = CG_T;
            next_tx_state = TX_R;
          end
        end
        TX_R: begin
          tx_code = CG_R;
          next_tx_state = TX_IDLE;
        end
      endcase
    end
    next_tx_sr = tx_load ? tx_code : {tx_sr[3:0], 1'b0};
    next_tx_cnt = tx_load ? 3'd0 : tx_cnt + 3'd1;
    // Key steps every bit; the seed is loaded once, after reset is released
    scr_bit = tx_sr[4] ^ tx_key[10] ^ tx_key[8];
    if (!tx_seeded) begin
      next_tx_key = {i_phy_addr, SEED_PAD};
    end else begin
      next_tx_key = {tx_key[9:0], tx_key[10] ^ tx_key[8]};
    end
    next_nrzi = o_tx_nrzi ^ scr_bit;
    next_mlt_idx = scr_bit ? mlt_idx + 2'd1 : mlt_idx;
    unique case (next_mlt_idx)
      2'd1: next_mlt3 = LVL_POS;
      2'd3: next_mlt3 = LVL_NEG;
      default: next_mlt3 = LVL_ZERO;
    endcase
  end

  // Transmit registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state <= TX_IDLE;
      tx_sr <= CG_IDLE;
      tx_cnt <= 3'd0;
      tx_key <= '0;
      tx_seeded <= 1'b0;
      o_tx_nrzi <= 1'b0;
      mlt_idx <= 2'd0;
      o_tx_mlt3 <= LVL_ZERO;
    end else begin
      tx_state <= next_tx_state;
      tx_sr <= next_tx_sr;
      tx_cnt <= next_tx_cnt;
      tx_key <= next_tx_key;
      tx_seeded <= 1'b1;
      o_tx_nrzi <= next_nrzi;
      mlt_idx <= next_mlt_idx;
      o_tx_mlt3 <= next_mlt3;
    end
  end

  a_mlt3_step: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_seeded && scr_bit |=> o_tx_mlt3 != $past(o_tx_mlt3)) else $error("level did not step");
  a_mlt3_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_seeded && !scr_bit |=> $stable(o_tx_mlt3)) else $error("level moved on a zero");
  a_tx_delims: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_load && tx_state == TX_IDLE && next_tx_state == TX_K |=> tx_sr == CG_J ##5 tx_sr == CG_K)
    else $error("K did not follow J");
  a_tx_end_pair: assert property (@(posedge i_clk) disable iff (i_rst)
    tx_load && tx_state == TX_DATA && next_tx_state == TX_R |=> tx_sr == CG_T ##5 tx_sr == CG_R)
    else $error("R missing after T");

  // ---------------- Receive front end ----------------
  logic [1:0] rx_lvl;       // Selected recovered level
  logic [1:0] rx_lvl_d;     // Previous level
  logic rx_nrzi;            // Rebuilt NRZI stream
  logic rx_nrzi_d;          // Previous NRZI bit
  logic next_rx_nrzi;
  logic rx_bit;             // Scrambled code bit

  // Phase pick, NRZI rebuild and sample pass-through
  always_comb begin
    next_rx_nrzi = rx_nrzi ^ (rx_lvl != rx_lvl_d);
    rx_bit = rx_nrzi ^ rx_nrzi_d;
  end

  // Front end registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dsp_sample <= 6'h00;
      rx_lvl <= LVL_ZERO;
      rx_lvl_d <= LVL_ZERO;
      rx_nrzi <= 1'b0;
      rx_nrzi_d <= 1'b0;
    end else begin
      o_dsp_sample <= i_adc_sample;
      rx_lvl <= i_rx_levels[2*i_phase_sel +: 2];
      rx_lvl_d <= rx_lvl;
      rx_nrzi <= next_rx_nrzi;
      rx_nrzi_d <= rx_nrzi;
    end
  end

  // ---------------- Descrambler sync and watchdog ----------------
  localparam int WDW = $clog2(IDLE_CYC + 1);
  logic [KEY_W-1:0] rx_key;
  logic [KEY_W-1:0] next_rx_key;
  logic [5:0] run;            // Matching or ones run length
  logic [5:0] next_run;
  logic [WDW-1:0] wdog;       // Cycles since idle was last seen
  logic [WDW-1:0] next_wdog;
  logic next_locked;
  logic rx_kbit;              // Key bit for this cycle
  logic dbit;                 // Descrambled bit
  logic next_dbit;

  // While hunting the key tracks the line, since idle descrambles to all ones
  always_comb begin
    rx_kbit = rx_key[10] ^ rx_key[8];
    next_dbit = rx_bit ^ rx_kbit;
    next_locked = o_rx_locked;
    next_wdog = '0;
    next_run = (next_dbit && run != 6'h3F) ? run + 6'd1 : (next_dbit ? run : 6'd0);
    if (!o_rx_locked) begin
      // Idle is all ones, so the inverted line bit is the far key bit
      next_rx_key = {rx_key[9:0], ~rx_bit};
      next_locked = (run == 6'(LOCK_RUN - 1)) && next_dbit;
    end else begin
      next_rx_key = {rx_key[9:0], rx_kbit};
      next_wdog = (run >= 6'(IDLE_RUN)) ? '0 : wdog + 1'b1;
      if (wdog == WDW'(IDLE_CYC - 1)) begin
        next_locked = 1'b0;
        next_run = 6'd0;
        next_wdog = '0;
      end
    end
  end

  // Sync registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_key <= '0;
      run <= 6'd0;
      wdog <= '0;
      o_rx_locked <= 1'b0;
      dbit <= 1'b0;
    end else begin
      rx_key <= next_rx_key;
      run <= next_run;
      wdog <= next_wdog;
      o_rx_locked <= next_locked;
      dbit <= next_dbit;
    end
  end

  a_watchdog_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_locked && wdog == WDW'(IDLE_CYC - 1) |=> !o_rx_locked ##1 !o_rx_dv)
    else $error("no resync after idle window");

  // ---------------- Alignment and decoding ----------------
  fep_rx_state_e rx_state;
  fep_rx_state_e next_rx_state;
  logic [9:0] win;            // Last ten descrambled bits
  logic [9:0] next_win;
  logic [2:0] gcnt;           // Bit position in an aligned group
  logic [2:0] next_gcnt;
  logic [4:0] hold;           // Delayed nibble {error, data}
  logic [4:0] next_hold;
  logic [4:0] code;           // Group just completed
  logic [4:0] dec;            // Decoded group
  logic [4:0] expect_cg;      // Group that completes the end pair
  logic [4:0] next_expect;
  logic grp_end;
  logic next_strobe;
  logic next_dv;
  logic next_er;
  logic next_crs;
  logic [3:0] next_d;

  // One nibble of delay makes room for the second preamble nibble
  always_comb begin
    next_win = {win[8:0], dbit};
    code = next_win[4:0];
    dec = fep_dec(code);
    grp_end = (gcnt == 3'd4);
    next_gcnt = grp_end ? 3'd0 : gcnt + 3'd1;
    next_rx_state = rx_state;
    next_hold = hold;
    next_expect = expect_cg;
    next_strobe = 1'b0;
    next_dv = o_rx_dv;
    next_er = o_rx_er;
    next_crs = o_crs;
    next_d = o_rx_d;
    if (!o_rx_locked) begin
      next_rx_state = RX_HUNT;
      next_dv = 1'b0;
      next_er = 1'b0;
      next_crs = 1'b0;
    end else begin
      unique case (rx_state)
        RX_HUNT: begin
          next_er = 1'b0;
          if (next_win == SSD_WIN) begin
            next_rx_state = RX_J;
            next_gcnt = 3'd0;
          end
        end
        RX_J: begin
          if (grp_end) begin
            next_strobe = 1'b1;
            if (code == CG_K) begin
              next_rx_state = RX_FRAME;
              next_dv = 1'b1;
              next_crs = 1'b1;
              next_d = NIB_PRE;
              next_hold = {1'b0, NIB_PRE};
            end else begin
              next_rx_state = RX_HUNT;
              next_er = 1'b1;
              next_d = NIB_BAD_SSD;
            end
          end
        end
        RX_FRAME: begin
          if (grp_end) begin
            next_strobe = 1'b1;
            next_er = hold[4];
            next_d = hold[3:0];
            next_hold = {!dec[4], dec[3:0]};
            if (code == CG_T || code == CG_IDLE) begin
              next_rx_state = RX_END;
              next_expect = (code == CG_T) ? CG_R : CG_IDLE;
            end
          end
        end
        RX_END: begin
          if (grp_end) begin
            next_strobe = 1'b1;
            if (code == expect_cg) begin
              next_rx_state = RX_HUNT;
              next_dv = 1'b0;
              next_crs = 1'b0;
              next_er = 1'b0;
            end else begin
              next_rx_state = RX_FRAME;
              next_er = 1'b1;
              next_hold = {!dec[4], dec[3:0]};
            end
          end
        end
      endcase
    end
  end

  // Decoder registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_state <= RX_HUNT;
      win <= 10'h000;
      gcnt <= 3'd0;
      hold <= 5'h00;
      expect_cg <= CG_R;
      o_rx_strobe <= 1'b0;
      o_rx_dv <= 1'b0;
      o_rx_er <= 1'b0;
      o_crs <= 1'b0;
      o_rx_d <= 4'h0;
    end else begin
      rx_state <= next_rx_state;
      win <= next_win;
      gcnt <= next_gcnt;
      hold <= next_hold;
      expect_cg <= next_expect;
      o_rx_strobe <= next_strobe;
      o_rx_dv <= next_dv;
      o_rx_er <= next_er;
      o_crs <= next_crs;
      o_rx_d <= next_d;
    end
  end

  a_ssd_preamble: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_locked && rx_state == RX_J && grp_end && code == CG_K |=> o_rx_dv && o_rx_d == NIB_PRE
    ##5 (o_rx_d == NIB_PRE || !o_rx_locked)) else $error("preamble nibbles wrong");
  a_bad_ssd: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_locked && rx_state == RX_J && grp_end && code != CG_K |=> o_rx_er && !o_rx_dv
    && o_rx_d == NIB_BAD_SSD) else $error("bad start not flagged");
  a_bad_group: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_locked && rx_state == RX_FRAME && grp_end && !dec[4] && code != CG_T && code != CG_IDLE
    |-> ##6 (o_rx_er || !o_rx_locked)) else $error("invalid group passed");
  a_end_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_locked && rx_state == RX_END && grp_end && code == expect_cg |=> !o_rx_dv && !o_crs)
    else $error("valid stayed after end");
  a_unlock_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_rx_locked |=> !o_rx_dv && !o_rx_er) else $error("output while unlocked");
endmodule

//--- pkg/fep_pkg.sv
// Shared constants, types and code-group tables for the fast ethernet coding path
package fep_pkg;

  // Clock and idle watchdog timing
  localparam int CLK_NS = 10;                          // Period of i_clk
  localparam int IDLE_WIN_NS = 40000;                  // Window in which idle must be seen
  localparam int IDLE_WIN_CYC = IDLE_WIN_NS / CLK_NS;  // Window as a count of bit cycles

  // Code-groups with a special meaning
  localparam logic [4:0] CG_IDLE = 5'h1F;  // Idle
  localparam logic [4:0] CG_J = 5'h18;     // First start delimiter group
  localparam logic [4:0] CG_K = 5'h11;     // Second start delimiter group
  localparam logic [4:0] CG_T = 5'h0D;     // First end delimiter group
  localparam logic [4:0] CG_R = 5'h07;     // Second end delimiter group
  localparam logic [4:0] CG_H = 5'h04;     // Transmit error group
  localparam logic [9:0] SSD_WIN = {CG_IDLE, CG_J};  // Idle followed by the first delimiter

  // Three-level line values
  localparam logic [1:0] LVL_ZERO = 2'h0;  // Middle level
  localparam logic [1:0] LVL_POS = 2'h1;   // Upper level
  localparam logic [1:0] LVL_NEG = 2'h3;   // Lower level

  // Fixed receive nibbles
  localparam logic [3:0] NIB_PRE = 4'h5;      // Preamble nibble sent for the start delimiter
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;  // Nibble sent for a broken start delimiter

  // Key generator
  localparam int KEY_W = 11;                 // Length of the key register
  localparam logic [5:0] SEED_PAD = 6'h2A;   // Low seed bits, keep the seed nonzero
  localparam int LOCK_RUN = 30;              // Matching bits needed to declare lock
  localparam int IDLE_RUN = 10;              // Run of ones that counts as idle seen

  // Transmit FIFO word layout
  localparam int TXW_W = 6;   // Word width
  localparam int TXW_EN = 5;  // Frame enable bit
  localparam int TXW_ER = 4;  // Transmit error bit
  localparam int TX_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_state_e;
  typedef enum logic [1:0] {RX_HUNT, RX_J, RX_FRAME, RX_END} fep_rx_state_e;

  // Nibble to code-group
  function automatic logic [4:0] fep_enc(input logic [3:0] n);
    logic [4:0] c;
    c = CG_IDLE;
    unique case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction

  // Code-group to {data valid, nibble}; every other group is invalid
  function automatic logic [4:0] fep_dec(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    case (c)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

endpackage

//--- logic/fep_fifo.sv
// Flop-based FIFO with valid and ready on both sides
`timescale 1ns/1ps
module fep_fifo #(
  parameter int W = 6,
  parameter int D = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);

  logic [W-1:0] mem [D];      // Storage entries
  logic [AW-1:0] wr_ptr;      // Next entry to fill
  logic [AW-1:0] rd_ptr;      // Oldest entry
  logic [CW-1:0] count;       // Entries held
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];

  // Pointer and count update; ready follows the registered count so it never glitches
  always_comb begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      o_ready <= (next_count != FULL);
    end
  end

  // Entry storage, one write port per entry
  for (genvar e = 0; e < D; e++) begin : g_ent
    always_ff @(posedge i_clk) begin
      if (push && wr_ptr == AW'(e)) begin
        mem[e] <= i_data;
      end
    end
  end
endmodule

//--- test/fep_mac_model.sv
// Switch fabric MAC model that pushes transmit words into the coding path
`timescale 1ns/1ps
module fep_mac_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic o_en,
  output logic o_er,
  output logic [3:0] o_d
);
  logic [5:0] words[$]; // Pending {enable, error, nibble}

  initial begin
    o_valid = 1'b0;
    o_en = 1'b0;
    o_er = 1'b0;
    o_d = 4'h0;
  end

  // Word held until taken; released nibble toggles so stale data is never trusted
  always @(posedge i_clk) begin
    if (!o_valid || i_ready) begin
      if (words.size() > 0) begin
        {o_en, o_er, o_d} <= words.pop_front();
        o_valid <= 1'b1;
      end else begin
        o_valid <= 1'b0;
        o_d <= ~o_d;
      end
    end
  end
endmodule

//--- test/fep_pcs_tb.sv
// Self-checking bench: line output looped back into the receive levels
`timescale 1ns/1ps
module fep_pcs_tb;
  import fep_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] phy_addr = 5'h03;
  logic [1:0] phase_sel = 2'h1;
  logic [5:0] adc = 6'h00;
  logic [5:0] adc_prev = 6'h00;
  logic [7:0] rx_levels = 8'h00;
  logic [31:0] seed = 32'hDA16; // Shared random source
  logic tx_valid, tx_ready, tx_en, tx_er, tx_nrzi, rx_strobe, rx_dv, rx_er, crs, rx_locked, n_prev;
  logic [3:0] tx_d, rx_d;
  logic [1:0] tx_mlt3, m_prev, last_nz;
  logic [5:0] dsp;
  logic [31:0] cap, cap_a; // First line bits after reset
  logic [4:0] exp_q[$]; // Expected {error, nibble} per receive strobe
  logic [4:0] e;
  logic ignore = 1'b0; // Set while a frame is expected to be aborted
  logic saw_full = 1'b0;
  logic lk_prev = 1'b0; // Lock one cycle ago; outputs fall one cycle after lock drops
  int bad_count, samples_checked, live, k;

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  fep_pcs #(.PHASES(4), .IDLE_CYC(300)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_phy_addr(phy_addr), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .i_tx_en(tx_en), .i_tx_er(tx_er), .i_tx_d(tx_d), .o_tx_nrzi(tx_nrzi), .o_tx_mlt3(tx_mlt3),
    .i_adc_sample(adc), .o_dsp_sample(dsp), .i_rx_levels(rx_levels), .i_phase_sel(phase_sel),
    .o_rx_strobe(rx_strobe), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs), .o_rx_d(rx_d),
    .o_rx_locked(rx_locked));

  fep_mac_model i_mac (
    .i_clk(clk), .i_ready(tx_ready), .o_valid(tx_valid), .o_en(tx_en), .o_er(tx_er), .o_d(tx_d));

  // Line stimulus; unselected phases carry a wrong level so a bad mux shows up
  always @(posedge clk) begin
    seed <= lfsr(seed);
    adc <= seed[5:0];
    adc_prev <= adc;
    for (int p = 0; p < 4; p++) begin
      rx_levels[2*p +: 2] <= (p == phase_sel) ? tx_mlt3 : ((tx_mlt3 == LVL_ZERO) ? LVL_POS : LVL_ZERO);
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Monitor at the falling edge, where registered outputs have settled
  always @(negedge clk) begin
    if (rst) begin
      live = 0;
      last_nz = LVL_ZERO;
      lk_prev = 1'b0;
    end else begin
      live++;
      if (live > 2) begin
        check("dsp sample", 32'(dsp), 32'(adc_prev));
        check("mlt3 step", 32'(tx_mlt3 != m_prev), 32'(tx_nrzi != n_prev));
        check("mlt3 level", 32'(tx_mlt3 == 2'h2), 0);
        if (m_prev == LVL_ZERO && tx_mlt3 != LVL_ZERO && last_nz != LVL_ZERO)
          check("mlt3 order", 32'(tx_mlt3), 32'((last_nz == LVL_POS) ? LVL_NEG : LVL_POS));
        if (!rx_locked && !lk_prev) check("unlocked rx", 32'({rx_dv, rx_er}), 0);
        // Oldest note is matched against each valid nibble strobe
        if (rx_strobe && rx_dv && !ignore) begin
          if (exp_q.size() == 0) begin
            check("extra nibble", 1, 0);
          end else begin
            e = exp_q.pop_front();
            check("rx error", 32'(rx_er), 32'(e[4]));
            if (!e[4]) check("rx nibble", 32'(rx_d), 32'(e[3:0]));
            check("carrier", 32'(crs), 1);
          end
        end
      end
      m_prev = tx_mlt3;
      n_prev = tx_nrzi;
      lk_prev = rx_locked;
      if (tx_mlt3 != LVL_ZERO) last_nz = tx_mlt3;
      if (!tx_ready) saw_full = 1'b1;
    end
  end

  // Reset, capture the first line bits, then wait for the receiver to lock
  task automatic do_reset(input logic [4:0] addr, input logic [1:0] ph);
    rst <= 1'b1;
    phy_addr <= addr;
    phase_sel <= ph;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cap = 0;
    repeat (32) begin
      @(negedge clk);
      cap = {cap[30:0], tx_nrzi};
    end
    for (k = 0; k < 600 && rx_locked !== 1'b1; k++) @(negedge clk);
    check("lock", 32'(rx_locked), 1);
  endtask

  // Frame words; the first two come back as preamble nibbles
  task automatic push_frame(input int n, input int err_at);
    logic [3:0] d;
    for (int i = 0; i < n; i++) begin
      d = seed[11:8];
      i_mac.words.push_back({1'b1, i == err_at, d});
      if (!ignore) exp_q.push_back({i == err_at, (i < 2) ? NIB_PRE : d});
      @(posedge clk);
    end
  endtask

  task automatic wait_end();
    for (k = 0; k < 3000 && (i_mac.words.size() > 0 || exp_q.size() > 0 || tx_valid); k++) @(negedge clk);
    repeat (30) @(negedge clk);
    check("frame end", 32'({rx_dv, crs}), 0);
    check("all nibbles", 32'(exp_q.size()), 0);
  endtask

  initial begin
    bad_count = 0;
    samples_checked = 0;
    @(posedge clk);
    do_reset(5'h03, 2'h1);
    cap_a = cap;
    $display("Test lock done");
    for (int f = 0; f < 3; f++) begin
      push_frame(8 + 6 * f, (f == 1) ? 5 : -1);
      wait_end();
    end
    check("fifo full seen", 32'(saw_full), 1);
    $display("Test frames done");
    // Frame longer than the idle window must be cut off
    ignore = 1'b1;
    push_frame(90, -1);
    for (k = 0; k < 800 && rx_locked !== 1'b0; k++) @(negedge clk);
    repeat (2) @(negedge clk);
    check("watchdog drop", 32'({rx_locked, rx_dv}), 0);
    for (k = 0; k < 2000 && (i_mac.words.size() > 0 || rx_locked !== 1'b1); k++) @(negedge clk);
    check("relock", 32'(rx_locked), 1);
    @(posedge clk);
    ignore = 1'b0;
    push_frame(10, -1);
    wait_end();
    $display("Test watchdog done");
    @(posedge clk);
    do_reset(5'h1C, 2'h2);
    check("seed differs", 32'(cap != cap_a), 1);
    @(posedge clk);
    push_frame(12, -1);
    wait_end();
    $display("Test second port done");
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("Watchdog expired");
    wrap_up();
  end
endmodule
